// ===== aclm_consts.svh
// offsets, field positions, reset values and constants of the access-control entry matcher
// Summary of operation
// - Source-port selector any: every TCP/UDP source port matches.
// - Source-port selector specific: 16-bit value, match on equality only.
// - Source-port selector range: bounds 0 to 65535, match inside the range.
// - Destination-port selector any: every TCP/UDP destination port matches.
// - Destination-port selector specific: 16-bit value, match on equality only.
// - Destination-port selector range: match when the port lies within the bounds.
// - FIN setting 0 needs FIN clear, 1 needs FIN set, any ignores it.
// - SYN setting 0 needs SYN clear, 1 needs SYN set, any ignores it.
// - RST setting 0 needs RST clear, 1 needs RST set, any ignores it.
// - PSH setting 0 needs PSH clear, 1 needs PSH set, any ignores it.
// - ACK setting 0 needs ACK clear, 1 needs ACK set, any ignores it.
// - URG setting 0 needs URG clear, 1 needs URG set, any ignores it.
// - EtherType condition is evaluated only for entries of the EtherType class.
// - EtherType selector any: every EtherType matches.
// - Specific EtherType 0x600..0xffff, not 0x800/0x806/0x86dd; match on equality.
// - Next-header any or specific; specific TCP or UDP enables port checks, specific TCP also flag checks.
`ifndef ACLM_CONSTS_SVH
`define ACLM_CONSTS_SVH

// register offsets
`define ACLM_SP_CFG    8'h00
`define ACLM_SP_LO     8'h04
`define ACLM_SP_HI     8'h08
`define ACLM_DP_CFG    8'h0c
`define ACLM_DP_LO     8'h10
`define ACLM_DP_HI     8'h14
`define ACLM_FLAGS     8'h18
`define ACLM_ENTRY     8'h1c
`define ACLM_ETYPE_VAL 8'h20
`define ACLM_STATUS    8'h24

// entry register fields
`define ACLM_ENT_CLS_LSB   0
`define ACLM_ENT_ETSPEC    2
`define ACLM_ENT_NHSPEC    3
`define ACLM_ENT_NHVAL_LSB 8

// status register fields
`define ACLM_ST_ETBAD   0
`define ACLM_ST_LASTHIT 1
`define ACLM_ST_CNT_LSB 16

// reset values: every condition don't-care
`define ACLM_FLAGS_RST 12'haaa
`define ACLM_PORT_RST  16'h0000
`define ACLM_ETYPE_RST 16'h0600
`define ACLM_NH_RST    8'h00

// protocol constants
`define ACLM_ETYPE_MIN  16'h0600
`define ACLM_ETYPE_IPV4 16'h0800
`define ACLM_ETYPE_ARP  16'h0806
`define ACLM_ETYPE_IPV6 16'h86dd
`define ACLM_NH_TCP     8'h06
`define ACLM_NH_UDP     8'h11
`define ACLM_NUM_FLAGS  6

`endif

// ===== aclm_matcher.sv
// match logic and configuration registers of one access-control entry
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "aclm_consts.svh"

module aclm_matcher #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // register port
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [31:0]               rdata_q,
  // frame in, result out
  input  wire aclm_pkg::aclm_frame_t frm_i,
  output aclm_pkg::aclm_result_t     res_q
);

  aclm_pkg::aclm_port_cfg_t sp_q;
  aclm_pkg::aclm_port_cfg_t sp_d;
  aclm_pkg::aclm_port_cfg_t dp_q;
  aclm_pkg::aclm_port_cfg_t dp_d;
  aclm_pkg::aclm_entry_t    ent_q;
  aclm_pkg::aclm_entry_t    ent_d;
  logic [11:0]              flags_q;
  logic [11:0]              flags_d;
  logic [15:0]              etval_q;
  logic [15:0]              etval_d;
  logic [CNT_W-1:0]         cnt_q;
  logic [CNT_W-1:0]         cnt_d;
  logic [31:0]              rdata_d;
  aclm_pkg::aclm_result_t   res_d;
  logic [31:0]              rd_mux;
  logic [5:0]               flag_ok;
  logic                     sp_ok;
  logic                     dp_ok;
  logic                     et_good;
  logic                     et_ok;
  logic                     nh_ok;
  logic                     l4_sel;
  logic                     is_tcp;
  logic                     hit_c;

  // port condition, bounds inclusive
  function automatic logic port_ok(
    input aclm_pkg::aclm_pmode_t mode,
    input logic [15:0]           port,
    input logic [15:0]           lo,
    input logic [15:0]           hi
  );
    logic r;
    r = 1'b0;
    case (mode)
      aclm_pkg::PM_ANY:  r = 1'b1;
      aclm_pkg::PM_SPEC: r = (port == lo);
      aclm_pkg::PM_RNG:  r = (port >= lo) && (port <= hi);
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  // per-flag conditions
  genvar i;
  generate
    for (i = 0; i < `ACLM_NUM_FLAGS; i++)
    begin : g_flag
      always_comb
      begin
        case (flags_q[2*i+1:2*i])
          aclm_pkg::FS_ZERO: flag_ok[i] = ~frm_i.tcp_flags[i];
          aclm_pkg::FS_ONE:  flag_ok[i] = frm_i.tcp_flags[i];
          default:           flag_ok[i] = 1'b1;
        endcase
      end
    end
  endgenerate

  // field matches
  always_comb
  begin
    sp_ok   = port_ok(sp_q.mode, frm_i.sport, sp_q.lo, sp_q.hi);
    dp_ok   = port_ok(dp_q.mode, frm_i.dport, dp_q.lo, dp_q.hi);
    et_good = (etval_q >= `ACLM_ETYPE_MIN) &&
              (etval_q != `ACLM_ETYPE_IPV4) &&
              (etval_q != `ACLM_ETYPE_ARP) &&
              (etval_q != `ACLM_ETYPE_IPV6);
    et_ok   = !ent_q.etype_spec || (et_good && (frm_i.etype == etval_q));
    nh_ok   = !ent_q.nh_spec || (frm_i.nxt_hdr == ent_q.nh_val);
    l4_sel  = ent_q.nh_spec &&
              ((ent_q.nh_val == `ACLM_NH_TCP) || (ent_q.nh_val == `ACLM_NH_UDP));
    is_tcp  = (frm_i.nxt_hdr == `ACLM_NH_TCP);
    case (ent_q.cls)
      aclm_pkg::FC_ANY:   hit_c = 1'b1;
      aclm_pkg::FC_ETYPE: hit_c = !frm_i.ipv6 && et_ok;
      aclm_pkg::FC_IPV6:  hit_c = frm_i.ipv6 && nh_ok &&
                                  (!l4_sel || (sp_ok && dp_ok &&
                                  (!is_tcp || (&flag_ok))));
      default:            hit_c = 1'b0;
    endcase
  end

  // register read mux
  always_comb
  begin
    case (addr)
      `ACLM_SP_CFG:    rd_mux = {30'h0, sp_q.mode};
      `ACLM_SP_LO:     rd_mux = {16'h0, sp_q.lo};
      `ACLM_SP_HI:     rd_mux = {16'h0, sp_q.hi};
      `ACLM_DP_CFG:    rd_mux = {30'h0, dp_q.mode};
      `ACLM_DP_LO:     rd_mux = {16'h0, dp_q.lo};
      `ACLM_DP_HI:     rd_mux = {16'h0, dp_q.hi};
      `ACLM_FLAGS:     rd_mux = {20'h0, flags_q};
      `ACLM_ENTRY:     rd_mux = {16'h0, ent_q.nh_val, 4'h0, ent_q.nh_spec,
                                 ent_q.etype_spec, ent_q.cls};
      `ACLM_ETYPE_VAL: rd_mux = {16'h0, etval_q};
      `ACLM_STATUS:
      begin
        rd_mux = 32'h0;
        rd_mux[`ACLM_ST_CNT_LSB +: CNT_W] = cnt_q;
        rd_mux[`ACLM_ST_LASTHIT]          = res_q.hit;
        rd_mux[`ACLM_ST_ETBAD]            = ent_q.etype_spec && !et_good;
      end
      default:         rd_mux = 32'h0;
    endcase
  end

  // next state of configuration, status and outputs
  always_comb
  begin
    sp_d    = sp_q;
    dp_d    = dp_q;
    flags_d = flags_q;
    ent_d   = ent_q;
    etval_d = etval_q;
    cnt_d   = cnt_q;
    if (wr)
    begin
      case (addr)
        `ACLM_SP_CFG:    sp_d.mode = aclm_pkg::aclm_pmode_t'(wdata[1:0]);
        `ACLM_SP_LO:     sp_d.lo   = wdata[15:0];
        `ACLM_SP_HI:     sp_d.hi   = wdata[15:0];
        `ACLM_DP_CFG:    dp_d.mode = aclm_pkg::aclm_pmode_t'(wdata[1:0]);
        `ACLM_DP_LO:     dp_d.lo   = wdata[15:0];
        `ACLM_DP_HI:     dp_d.hi   = wdata[15:0];
        `ACLM_FLAGS:     flags_d   = wdata[11:0];
        `ACLM_ENTRY:
        begin
          ent_d.cls        = aclm_pkg::aclm_class_t'(wdata[`ACLM_ENT_CLS_LSB +: 2]);
          ent_d.etype_spec = wdata[`ACLM_ENT_ETSPEC];
          ent_d.nh_spec    = wdata[`ACLM_ENT_NHSPEC];
          ent_d.nh_val     = wdata[`ACLM_ENT_NHVAL_LSB +: 8];
        end
        `ACLM_ETYPE_VAL: etval_d   = wdata[15:0];
        default:         etval_d   = etval_q;
      endcase
    end
    res_d.vld = frm_i.vld;
    res_d.hit = frm_i.vld && hit_c;
    if (res_d.hit)
    begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    rdata_d = rd ? rd_mux : 32'h0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sp_q    <= '{aclm_pkg::PM_ANY, `ACLM_PORT_RST, `ACLM_PORT_RST};
      dp_q    <= '{aclm_pkg::PM_ANY, `ACLM_PORT_RST, `ACLM_PORT_RST};
      flags_q <= `ACLM_FLAGS_RST;
      ent_q   <= '{aclm_pkg::FC_ANY, 1'b0, 1'b0, `ACLM_NH_RST};
      etval_q <= `ACLM_ETYPE_RST;
      cnt_q   <= '0;
      res_q   <= '0;
      rdata_q <= 32'h0;
    end
    else
    begin
      sp_q    <= sp_d;
      dp_q    <= dp_d;
      flags_q <= flags_d;
      ent_q   <= ent_d;
      etval_q <= etval_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
      rdata_q <= rdata_d;
    end
  end

  // checks on the result against the previous frame and configuration
  logic ip4l_q;
  always_ff @(posedge clk_sys)
  begin
    ip4l_q <= (ent_q.cls == aclm_pkg::FC_IPV6) && l4_sel;
  end

  property p_sport_spec;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(sp_q.mode == aclm_pkg::PM_SPEC))
    |-> ($past(frm_i.sport) == $past(sp_q.lo));
  endproperty
  a_sport_spec: assert property (p_sport_spec) else $error("source port mismatch hit");

  property p_sport_rng;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(sp_q.mode == aclm_pkg::PM_RNG))
    |-> ($past(frm_i.sport) >= $past(sp_q.lo)) && ($past(frm_i.sport) <= $past(sp_q.hi));
  endproperty
  a_sport_rng: assert property (p_sport_rng) else $error("source port out of range hit");

  property p_dport_spec;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(dp_q.mode == aclm_pkg::PM_SPEC))
    |-> ($past(frm_i.dport) == $past(dp_q.lo));
  endproperty
  a_dport_spec: assert property (p_dport_spec) else $error("dest port mismatch hit");

  property p_dport_rng;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(dp_q.mode == aclm_pkg::PM_RNG))
    |-> ($past(frm_i.dport) >= $past(dp_q.lo)) && ($past(frm_i.dport) <= $past(dp_q.hi));
  endproperty
  a_dport_rng: assert property (p_dport_rng) else $error("dest port out of range hit");

  property p_fin;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(is_tcp) && $past(flags_q[1:0] == 2'h1))
    |-> $past(frm_i.tcp_flags[0]);
  endproperty
  a_fin: assert property (p_fin) else $error("hit without required fin");

  property p_syn;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && ip4l_q && $past(is_tcp) && $past(flags_q[3:2] == 2'h0))
    |-> !$past(frm_i.tcp_flags[1]);
  endproperty
  a_syn: assert property (p_syn) else $error("hit with excluded syn");

  property p_etype;
    @(posedge clk_sys) disable iff (srst)
    $past(frm_i.vld && ent_q.cls == aclm_pkg::FC_ETYPE && ent_q.etype_spec)
    |-> (res_q.hit == $past(et_good && frm_i.etype == etval_q && !frm_i.ipv6));
  endproperty
  a_etype: assert property (p_etype) else $error("ethertype result wrong");

  property p_nh;
    @(posedge clk_sys) disable iff (srst)
    (res_q.hit && $past(ent_q.cls == aclm_pkg::FC_IPV6 && ent_q.nh_spec))
    |-> ($past(frm_i.nxt_hdr) == $past(ent_q.nh_val)) && $past(frm_i.ipv6);
  endproperty
  a_nh: assert property (p_nh) else $error("next header mismatch hit");

endmodule

// ===== aclm_pkg.sv
// types of the access-control entry matcher
package aclm_pkg;

  // port selector mode
  typedef enum logic [1:0] {
    PM_ANY  = 2'h0,
    PM_SPEC = 2'h1,
    PM_RNG  = 2'h2
  } aclm_pmode_t;

  // per-flag setting, 2'h3 also reads as any
  typedef enum logic [1:0] {
    FS_ZERO = 2'h0,
    FS_ONE  = 2'h1,
    FS_ANY  = 2'h2
  } aclm_fset_t;

  // frame-type class of the entry
  typedef enum logic [1:0] {
    FC_ANY   = 2'h0,
    FC_ETYPE = 2'h1,
    FC_IPV6  = 2'h2
  } aclm_class_t;

  typedef struct packed {
    aclm_pmode_t mode;
    logic [15:0] lo;
    logic [15:0] hi;
  } aclm_port_cfg_t;

  typedef struct packed {
    aclm_class_t cls;
    logic        etype_spec;
    logic        nh_spec;
    logic [7:0]  nh_val;
  } aclm_entry_t;

  // flags: [5] urg [4] ack [3] psh [2] rst [1] syn [0] fin
  typedef struct packed {
    logic        vld;
    logic        ipv6;
    logic [15:0] etype;
    logic [7:0]  nxt_hdr;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [5:0]  tcp_flags;
  } aclm_frame_t;

  typedef struct packed {
    logic vld;
    logic hit;
  } aclm_result_t;

endpackage

// ===== tb_top.sv
// self-checking testbench of the access-control entry matcher
`timescale 1ns/10ps
`include "aclm_consts.svh"

module tb_top;
  logic                   clk_sys;
  logic                   srst;
  logic [7:0]             addr;
  logic [31:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [31:0]            rdata_q;
  aclm_pkg::aclm_frame_t  frm_i;
  aclm_pkg::aclm_frame_t  f;
  aclm_pkg::aclm_result_t res_q;
  int                     miscompares;
  int                     compares;
  int                     hits;
  int                     cycles;
  logic                   last_hit;
  logic [15:0]            tv [4];
  logic                   te [4];
  logic [11:0]            fl;

  aclm_matcher aclm_matcher_inst (
    .clk_sys (clk_sys),
    .srst    (srst),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .rdata_q (rdata_q),
    .frm_i   (frm_i),
    .res_q   (res_q)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    chk(rdata_q, exp, "read data");
    @(negedge clk_sys);
    chk(rdata_q, 32'h0, "read data length");
  endtask

  // one frame, result pulse checked in its cycle and gone after
  task automatic send(input logic exp);
    @(posedge clk_sys);
    frm_i <= f;
    @(posedge clk_sys);
    frm_i.vld <= 1'b0;
    @(negedge clk_sys);
    chk({30'h0, res_q.vld, res_q.hit}, {30'h0, 1'b1, exp}, "frame result");
    @(negedge clk_sys);
    chk({31'h0, res_q.vld}, 32'h0, "result pulse length");
    hits += int'(exp);
    last_hit = exp;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test;
    end
  end

  initial
  begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    frm_i = '0; miscompares = 0; compares = 0; hits = 0; cycles = 0; last_hit = 1'b0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(`ACLM_SP_CFG, 32'h0);
    rchk(`ACLM_FLAGS, 32'h0000_0aaa);
    rchk(`ACLM_ETYPE_VAL, 32'h0000_0600);
    rchk(`ACLM_ENTRY, 32'h0);
    wreg(`ACLM_STATUS, 32'hffff_ffff);
    rchk(`ACLM_STATUS, 32'h0);
    wreg(8'h28, 32'h0000_1234);
    rchk(8'h28, 32'h0);
    f = '{vld:1'b1, ipv6:1'b1, etype:16'h86dd, nxt_hdr:8'h06, sport:16'h0050,
          dport:16'h1f90, tcp_flags:6'h00};
    send(1'b1);
    // ipv6 class, next header tcp
    wreg(`ACLM_ENTRY, 32'h0000_060a);
    send(1'b1);
    wreg(`ACLM_SP_CFG, 32'h1);
    wreg(`ACLM_SP_LO, 32'h0000_ffff);
    f.sport = 16'hffff;
    send(1'b1);
    f.sport = 16'hfffe;
    send(1'b0);
    wreg(`ACLM_SP_CFG, 32'h2);
    wreg(`ACLM_SP_LO, 32'h0000_0064);
    wreg(`ACLM_SP_HI, 32'h0000_00c8);
    tv = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
    te = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      f.sport = tv[i];
      send(te[i]);
    end
    wreg(`ACLM_SP_CFG, 32'h0);
    wreg(`ACLM_DP_CFG, 32'h1);
    wreg(`ACLM_DP_LO, 32'h0);
    f.dport = 16'h0000;
    send(1'b1);
    f.dport = 16'h0001;
    send(1'b0);
    wreg(`ACLM_DP_CFG, 32'h2);
    wreg(`ACLM_DP_LO, 32'h0000_0010);
    wreg(`ACLM_DP_HI, 32'h0000_0020);
    tv = '{16'h000f, 16'h0010, 16'h0020, 16'h0021};
    for (int i = 0; i < 4; i++)
    begin
      f.dport = tv[i];
      send(te[i]);
    end
    wreg(`ACLM_DP_CFG, 32'h0);
    // each flag: must-clear then must-set, frame flag clear and set
    for (int i = 0; i < 6; i++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        fl = (12'haaa & ~(12'h003 << (2 * i))) | (12'(s) << (2 * i));
        wreg(`ACLM_FLAGS, {20'h0, fl});
        f.tcp_flags = 6'h00;
        send(s == 0);
        f.tcp_flags = 6'h01 << i;
        send(s == 1);
      end
    end
    // all enabled conditions together
    wreg(`ACLM_SP_CFG, 32'h1);
    wreg(`ACLM_SP_LO, 32'h0000_0005);
    wreg(`ACLM_FLAGS, 32'h0000_0aa9);
    f.sport = 16'h0005;
    f.tcp_flags = 6'h00;
    send(1'b0);
    f.tcp_flags = 6'h01;
    send(1'b1);
    f.sport = 16'h0006;
    send(1'b0);
    // udp: flags ignored, ports still checked
    wreg(`ACLM_ENTRY, 32'h0000_110a);
    f.nxt_hdr = 8'h11;
    f.tcp_flags = 6'h00;
    f.sport = 16'h0005;
    send(1'b1);
    f.sport = 16'h0006;
    send(1'b0);
    // next header any: no port checks, ethertype not evaluated
    wreg(`ACLM_ENTRY, 32'h0000_0006);
    wreg(`ACLM_ETYPE_VAL, 32'h0000_88cc);
    send(1'b1);
    // ethertype class
    wreg(`ACLM_SP_CFG, 32'h0);
    wreg(`ACLM_FLAGS, 32'h0000_0aaa);
    wreg(`ACLM_ENTRY, 32'h0000_0001);
    f.ipv6 = 1'b0;
    f.etype = 16'h1234;
    send(1'b1);
    wreg(`ACLM_ENTRY, 32'h0000_0005);
    send(1'b0);
    f.etype = 16'h88cc;
    send(1'b1);
    f.etype = 16'h88cd;
    send(1'b0);
    wreg(`ACLM_ETYPE_VAL, 32'h0000_0600);
    f.etype = 16'h0600;
    send(1'b1);
    tv = '{16'h0800, 16'h0806, 16'h86dd, 16'h05ff};
    for (int i = 0; i < 4; i++)
    begin
      wreg(`ACLM_ETYPE_VAL, {16'h0, tv[i]});
      f.etype = tv[i];
      send(1'b0);
      rchk(`ACLM_STATUS, {hits[15:0], 14'h0, last_hit, 1'b1});
    end
    end_of_test;
  end
endmodule
